// [adms_pkg.sv]
// Constants and types shared by the mode sequencer
package adms_pkg;
	localparam real CLK_PERIOD_NS = 100.0;
	// Mode timings at the nominal converter clock, as printed
	localparam real T_CONV_FAST_MS = 12.5;
	localparam real T_CONV_SLOW_MS = 100.0;
	localparam real T_CAL_FAST_MS = 101.28;
	localparam real T_CAL_SLOW_MS = 801.02;
	localparam real T_STBY_FAST_MS = 12.46;
	localparam real T_STBY_SLOW_MS = 99.96;
	localparam real T_WAKE_FAST_MS = 52.51;
	localparam real T_WAKE_SLOW_MS = 401.8;
	localparam real T_WCAL_FAST_MS = 103.0;
	localparam real T_WCAL_SLOW_MS = 803.0;
	localparam real T_RES_INT_US = 7.95;
	localparam real T_RES_EXT_US = 0.16;
	localparam real T_RES_XTAL_MS = 5.6;
	localparam int CONV_FAST_CYC = int'($ceil(T_CONV_FAST_MS * 1.0e6 / CLK_PERIOD_NS));
	localparam int CONV_SLOW_CYC = int'($ceil(T_CONV_SLOW_MS * 1.0e6 / CLK_PERIOD_NS));
	localparam int CAL_FAST_CYC = int'($ceil(T_CAL_FAST_MS * 1.0e6 / CLK_PERIOD_NS));
	localparam int CAL_SLOW_CYC = int'($ceil(T_CAL_SLOW_MS * 1.0e6 / CLK_PERIOD_NS));
	localparam int STBY_FAST_CYC = int'($ceil(T_STBY_FAST_MS * 1.0e6 / CLK_PERIOD_NS));
	localparam int STBY_SLOW_CYC = int'($ceil(T_STBY_SLOW_MS * 1.0e6 / CLK_PERIOD_NS));
	localparam int WAKE_FAST_CYC = int'($ceil(T_WAKE_FAST_MS * 1.0e6 / CLK_PERIOD_NS));
	localparam int WAKE_SLOW_CYC = int'($ceil(T_WAKE_SLOW_MS * 1.0e6 / CLK_PERIOD_NS));
	localparam int WCAL_FAST_CYC = int'($ceil(T_WCAL_FAST_MS * 1.0e6 / CLK_PERIOD_NS));
	localparam int WCAL_SLOW_CYC = int'($ceil(T_WCAL_SLOW_MS * 1.0e6 / CLK_PERIOD_NS));
	localparam int RES_INT_CYC = int'($floor(T_RES_INT_US * 1.0e3 / CLK_PERIOD_NS));
	localparam int RES_EXT_CYC_RAW = int'($floor(T_RES_EXT_US * 1.0e3 / CLK_PERIOD_NS));
	localparam int RES_EXT_CYC = (RES_EXT_CYC_RAW < 1) ? 1 : RES_EXT_CYC_RAW;
	localparam int RES_XTAL_CYC = int'($floor(T_RES_XTAL_MS * 1.0e6 / CLK_PERIOD_NS));
	// Frame bit counts
	localparam logic [4:0] DATA_BITS = 5'h18;
	localparam logic [4:0] FORCE_HIGH_EDGE = 5'h19;
	localparam logic [4:0] CAL_EDGE = 5'h1A;
	localparam logic [4:0] BITS_MAX = 5'h1F;
	// Register byte offsets
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_RESULT = 4'h4;
	localparam logic [3:0] REG_STATUS = 4'h8;
	// Control fields and reset values
	localparam int CTRL_FAST_BIT = 0;
	localparam int CTRL_SRC_LSB = 1;
	localparam logic CTRL_FAST_RST = 1'b0;
	localparam logic [1:0] CTRL_SRC_RST = 2'h0;
	localparam logic [23:0] RESULT_RST = 24'h00_0000;
	// Clock source codes
	localparam logic [1:0] SRC_INTERNAL = 2'h0;
	localparam logic [1:0] SRC_EXTERNAL = 2'h1;
	localparam logic [1:0] SRC_CRYSTAL = 2'h2;
	typedef enum logic [2:0] {
		ST_PWRDN,
		ST_RESUME,
		ST_CONVERT,
		ST_DATA,
		ST_CAL,
		ST_STANDBY,
		ST_WAKE
	} adms_state_e;
endpackage

// [adms_sync.sv]
// Two-flop synchroniser with edge detection for an outside input
`timescale 1ns/1ps
module adms_sync (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic d_i,
	output logic level_o,
	output logic rise_o,
	output logic fall_o
);
	typedef struct packed {
		logic meta;
		logic sync;
		logic last;
		logic rise;
		logic fall;
	} adms_sync_s;
	adms_sync_s s_r;
	adms_sync_s s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.meta = d_i;
		s_nxt.sync = s_r.meta;
		s_nxt.last = s_r.sync;
		s_nxt.rise = s_r.sync & ~s_r.last;
		s_nxt.fall = ~s_r.sync & s_r.last;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign level_o = s_r.last;
	assign rise_o = s_r.rise;
	assign fall_o = s_r.fall;
endmodule

// [adms_sequencer.sv]
// Operating-mode sequencer of a pin-driven delta-sigma converter
// Behaviour
// [R1] Two extra shift clocks after data request calibration
// [R2] 25th shift clock drives output line high
// [R3] Calibration starts on 26th shift-clock falling edge
// [R4] Later shift clocks never abort calibration
// [R5] Calibration swaps analog inputs for internal signal
// [R6] Calibration end pulls line low, data valid
// [R7] Calibration lasts 101.28 or 801.02 ms
// [R8] Holding shift clock high after ready enters standby
// [R9] Host raises shift clock within allowed window
// [R10] Standby only after 12.46 or 99.96 ms high
// [R11] Standby powers analog down, line stays high
// [R12] Shift clock low wakes, data after 52.51/401.8 ms
// [R13] 25 clocks then standby calibrates on wake-up
// [R14] Power-down pin low shuts down and resets
// [R15] Resume after release per clock source
// [R16] Host toggles power-down pin at power-up
// [R17] Host keeps toggle pulses at least 26 us
// [R18] Timings scale with clock period
// [R19] Data bits leave MSB first on rising edges
// [R20] Rate select low slow, high fast
// [R21] Short high shift clock keeps converting normally
`timescale 1ns/1ps
module adms_sequencer
	import adms_pkg::*;
#(
	parameter int CONV_FAST = CONV_FAST_CYC,
	parameter int CONV_SLOW = CONV_SLOW_CYC,
	parameter int CAL_FAST = CAL_FAST_CYC,
	parameter int CAL_SLOW = CAL_SLOW_CYC,
	parameter int STBY_FAST = STBY_FAST_CYC,
	parameter int STBY_SLOW = STBY_SLOW_CYC,
	parameter int WAKE_FAST = WAKE_FAST_CYC,
	parameter int WAKE_SLOW = WAKE_SLOW_CYC,
	parameter int WCAL_FAST = WCAL_FAST_CYC,
	parameter int WCAL_SLOW = WCAL_SLOW_CYC,
	parameter int RES_XTAL = RES_XTAL_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic shift_clk_i,
	input wire logic power_down_n_i,
	output logic ready_and_serial_out_o,
	output logic analog_power_o,
	output logic cal_signal_sel_o
);
	typedef struct packed {
		adms_state_e st;
		logic [23:0] tmr;
		logic [23:0] hold;
		logic [4:0] bits;
		logic [23:0] shreg;
		logic cal_wake;
		logic dout;
		logic ana_on;
		logic cal_sel;
		logic fast;
		logic [1:0] src;
		logic [23:0] result;
		logic ack;
		logic [31:0] rdat;
	} adms_seq_s;

	adms_seq_s s_r;
	adms_seq_s s_nxt;
	logic sclk_lvl;
	logic sclk_rise;
	logic sclk_fall;
	logic pdn_lvl;
	logic [23:0] conv_lim;
	logic [23:0] cal_lim;
	logic [23:0] stby_lim;
	logic [23:0] wake_lim;
	logic [23:0] res_lim;

	// Both pins come from outside this clock domain
	adms_sync u_sclk_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i(shift_clk_i),
		.level_o(sclk_lvl),
		.rise_o(sclk_rise),
		.fall_o(sclk_fall)
	);

	adms_sync u_pdn_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i(power_down_n_i),
		.level_o(pdn_lvl),
		.rise_o(),
		.fall_o()
	);

	// Timer limits, all counted in cycles of this clock
	always_comb begin
		conv_lim = s_r.fast ? 24'(CONV_FAST - 1) : 24'(CONV_SLOW - 1); // [R20]
		cal_lim = s_r.fast ? 24'(CAL_FAST - 1) : 24'(CAL_SLOW - 1); // [R7]
		stby_lim = s_r.fast ? 24'(STBY_FAST - 1) : 24'(STBY_SLOW - 1); // [R10]
		if (s_r.cal_wake) begin
			wake_lim = s_r.fast ? 24'(WCAL_FAST - 1) : 24'(WCAL_SLOW - 1); // [R13]
		end else begin
			wake_lim = s_r.fast ? 24'(WAKE_FAST - 1) : 24'(WAKE_SLOW - 1); // [R12]
		end
		case (s_r.src)
			SRC_EXTERNAL: res_lim = 24'(RES_EXT_CYC - 1); // [R15]
			SRC_CRYSTAL: res_lim = 24'(RES_XTAL - 1); // [R15]
			default: res_lim = 24'(RES_INT_CYC - 1); // [R15]
		endcase
	end

	always_comb begin
		s_nxt = s_r;
		s_nxt.tmr = s_r.tmr + 24'h00_0001;

		// Bus slave: one wait state, ack dropped after one cycle
		s_nxt.ack = cyc_i & stb_i & ~s_r.ack;
		s_nxt.rdat = 32'h0000_0000;
		if (cyc_i && stb_i && !s_r.ack) begin
			if (we_i) begin
				if (adr_i == REG_CTRL && sel_i[0]) begin
					s_nxt.fast = dat_i[CTRL_FAST_BIT]; // [R20]
					s_nxt.src = dat_i[CTRL_SRC_LSB +: 2];
				end
				if (adr_i == REG_RESULT) begin
					if (sel_i[0]) begin
						s_nxt.result[7:0] = dat_i[7:0];
					end
					if (sel_i[1]) begin
						s_nxt.result[15:8] = dat_i[15:8];
					end
					if (sel_i[2]) begin
						s_nxt.result[23:16] = dat_i[23:16];
					end
				end
			end else begin
				case (adr_i)
					REG_CTRL: begin
						s_nxt.rdat[CTRL_FAST_BIT] = s_r.fast;
						s_nxt.rdat[CTRL_SRC_LSB +: 2] = s_r.src;
					end
					REG_RESULT: s_nxt.rdat[23:0] = s_r.result;
					REG_STATUS: begin
						s_nxt.rdat[2:0] = s_r.st;
						s_nxt.rdat[7:3] = s_r.bits;
						s_nxt.rdat[8] = s_r.cal_wake;
						s_nxt.rdat[9] = s_r.ana_on;
						s_nxt.rdat[10] = s_r.cal_sel;
						s_nxt.rdat[11] = s_r.dout;
					end
					default: s_nxt.rdat = 32'h0000_0000;
				endcase
			end
		end

		case (s_r.st)
			ST_PWRDN: begin
				s_nxt.dout = 1'b1;
				s_nxt.ana_on = 1'b0;
				s_nxt.cal_sel = 1'b0;
				s_nxt.tmr = '0;
				if (pdn_lvl) begin
					s_nxt.st = ST_RESUME;
				end
			end
			ST_RESUME: begin
				if (s_r.tmr >= res_lim) begin // [R15]
					s_nxt.st = ST_CONVERT;
					s_nxt.ana_on = 1'b1;
					s_nxt.tmr = '0;
				end
			end
			ST_CONVERT: begin
				s_nxt.dout = 1'b1;
				if (s_r.tmr >= conv_lim) begin
					s_nxt.st = ST_DATA;
				end
			end
			ST_DATA: begin
				if (sclk_rise) begin
					if (s_r.bits != BITS_MAX) begin
						s_nxt.bits = s_r.bits + 5'h01;
					end
					if (s_r.bits < DATA_BITS) begin
						s_nxt.dout = s_r.shreg[23]; // [R19]
						s_nxt.shreg = {s_r.shreg[22:0], 1'b0}; // [R19]
					end else begin
						s_nxt.dout = 1'b1; // [R2]
					end
				end
				// Holding high long enough means standby, else nothing
				if (sclk_lvl) begin
					s_nxt.hold = s_r.hold + 24'h00_0001; // [R8]
				end else begin
					s_nxt.hold = '0; // [R21]
				end
				if (sclk_fall && s_r.bits == CAL_EDGE) begin
					s_nxt.st = ST_CAL; // [R1] [R3]
					s_nxt.tmr = '0;
					s_nxt.cal_sel = 1'b1; // [R5]
					s_nxt.dout = 1'b1;
				end else if (sclk_lvl && s_r.hold >= stby_lim) begin
					s_nxt.st = ST_STANDBY; // [R10]
					s_nxt.dout = 1'b1; // [R11]
					s_nxt.ana_on = 1'b0; // [R11]
					s_nxt.cal_wake = (s_r.bits == FORCE_HIGH_EDGE); // [R13]
				end else if (s_r.tmr >= conv_lim) begin
					// Unread data is overwritten by the next result
					s_nxt.tmr = '0;
				end
			end
			ST_CAL: begin
				// Shift clocks are ignored until the cycle ends
				s_nxt.dout = 1'b1; // [R4]
				if (s_r.tmr >= cal_lim) begin
					s_nxt.st = ST_DATA; // [R6]
				end
			end
			ST_STANDBY: begin
				s_nxt.dout = 1'b1; // [R11]
				s_nxt.tmr = '0;
				if (!sclk_lvl) begin
					s_nxt.st = ST_WAKE; // [R12]
					s_nxt.ana_on = 1'b1;
					s_nxt.cal_sel = s_r.cal_wake; // [R13]
				end
			end
			ST_WAKE: begin
				s_nxt.dout = 1'b1;
				if (s_r.tmr >= wake_lim) begin
					s_nxt.st = ST_DATA; // [R12] [R13]
				end
			end
			default: begin
				s_nxt.st = ST_PWRDN;
			end
		endcase

		// Any path into data-ready loads a fresh, settled word
		if (s_nxt.st == ST_DATA && (s_r.st != ST_DATA ||
				(s_r.tmr >= conv_lim && s_nxt.tmr == '0))) begin
			s_nxt.tmr = '0;
			s_nxt.hold = '0;
			s_nxt.bits = '0;
			s_nxt.shreg = s_r.result;
			s_nxt.dout = 1'b0; // [R6]
			s_nxt.cal_sel = 1'b0; // [R6]
			s_nxt.cal_wake = 1'b0;
			s_nxt.ana_on = 1'b1;
		end

		// Power-down wins over every mode and clears the sequencer state; control and result registers keep their values
		if (!pdn_lvl) begin
			s_nxt.st = ST_PWRDN; // [R14]
			s_nxt.tmr = '0;
			s_nxt.hold = '0;
			s_nxt.bits = '0;
			s_nxt.shreg = '0;
			s_nxt.cal_wake = 1'b0;
			s_nxt.dout = 1'b1;
			s_nxt.ana_on = 1'b0;
			s_nxt.cal_sel = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r <= '0;
			s_r.st <= ST_PWRDN;
			s_r.dout <= 1'b1;
			s_r.fast <= CTRL_FAST_RST;
			s_r.src <= CTRL_SRC_RST;
			s_r.result <= RESULT_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Time counts derive from this clock, so they scale with it
	assign ready_and_serial_out_o = s_r.dout; // [R18]
	assign analog_power_o = s_r.ana_on;
	assign cal_signal_sel_o = s_r.cal_sel;
	assign dat_o = s_r.rdat;
	assign ack_o = s_r.ack;
endmodule

// [adms_assertions.sv]
// Port checks for the mode sequencer
`timescale 1ns/1ps
module adms_assertions #(
	parameter int STBY = 20
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ack_o,
	input wire logic shift_clk_i,
	input wire logic power_down_n_i,
	input wire logic ready_and_serial_out_o,
	input wire logic analog_power_o,
	input wire logic cal_signal_sel_o
);
	int hi_cnt;
	always_ff @(posedge clk_i) begin
		if (rst_i || !shift_clk_i) hi_cnt <= 0;
		else hi_cnt <= hi_cnt + 1;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	chk_ack_single: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	chk_pd_shut: assert property (
		!power_down_n_i [*5] |-> !analog_power_o && ready_and_serial_out_o)
		else $error("power-down did not shut down");
	chk_off_line_high: assert property (
		!analog_power_o |-> ready_and_serial_out_o)
		else $error("line low while analog off");
	chk_cal_powered: assert property (
		cal_signal_sel_o |-> analog_power_o)
		else $error("calibration with analog off");
	chk_cal_end_low: assert property (
		$fell(cal_signal_sel_o) && power_down_n_i
		|-> ##[0:1] !ready_and_serial_out_o)
		else $error("line not low after calibration");
	chk_cal_start: assert property (
		$rose(cal_signal_sel_o) |-> $past(ready_and_serial_out_o))
		else $error("calibration began with line low");
	chk_stby_time: assert property (
		$fell(analog_power_o) && power_down_n_i |-> hi_cnt >= STBY)
		else $error("standby entered too early");
	chk_wake_power: assert property (
		$fell(shift_clk_i) && !analog_power_o && power_down_n_i
		|-> ##[1:8] analog_power_o)
		else $error("no wake on shift clock low");
	chk_cal_hold: assert property (
		$rose(cal_signal_sel_o) |-> cal_signal_sel_o [*8])
		else $error("calibration cut short");
	cover property ($rose(cal_signal_sel_o));
	cover property ($fell(analog_power_o) && power_down_n_i);
	cover property (ack_o);
endmodule
bind adms_sequencer adms_assertions #(.STBY(STBY_FAST)) u_chk (
	.clk_i(clk_i), .rst_i(rst_i), .ack_o(ack_o),
	.shift_clk_i(shift_clk_i), .power_down_n_i(power_down_n_i),
	.ready_and_serial_out_o(ready_and_serial_out_o),
	.analog_power_o(analog_power_o), .cal_signal_sel_o(cal_signal_sel_o));

// [adms_host.sv]
// Host model driving shift clock and power-down pin
`timescale 1ns/1ps
module adms_host (
	input wire logic clk_i,
	output logic shift_clk_o,
	output logic power_down_n_o
);
	initial begin
		shift_clk_o = 1'b0;
		power_down_n_o = 1'b0;
	end
	// Raised at once after ready, well inside the allowed window
	task automatic level(input logic v, input int n);
		shift_clk_o <= v;
		repeat (n) @(posedge clk_i);
	endtask
	// 800 ns period; idles low between frames
	task automatic clocks(input int n);
		repeat (n) begin
			level(1'b1, 4);
			level(1'b0, 4);
		end
	endtask
	task automatic pd(input logic v, input int n);
		power_down_n_o <= v;
		repeat (n) @(posedge clk_i);
	endtask
	// Supplies taken as stable from time zero
	task automatic power_up;
		pd(1'b0, 100);
		pd(1'b1, 260);
		pd(1'b0, 260);
		pd(1'b1, 0);
	endtask
endmodule

// [adms_sequencer_tb.sv]
// Self-checking bench for the mode sequencer
`timescale 1ns/1ps
module adms_sequencer_tb;
	localparam int CAL_F = 60;
	localparam int CAL_S = 90;
	localparam int WAKE = 30;
	localparam int WCAL = 50;
	localparam int CONV = 2000;
	localparam logic [23:0] WORD = 24'hA5_3C96;
	localparam int XTAL = 10;
	logic clk_i;
	logic rst_i;
	logic cyc, stb, we;
	logic [3:0] adr, sel;
	logic [31:0] dat, dat_o, q;
	logic ack_o, sdo, apwr, csel, sclk, pd_n;
	int errors = 0;
	int check_count = 0;
	int n;
	always #50 clk_i = ~clk_i;
	adms_sequencer #(.CONV_FAST(CONV), .CONV_SLOW(3000), .CAL_FAST(CAL_F),
		.CAL_SLOW(CAL_S), .STBY_FAST(20), .STBY_SLOW(20), .WAKE_FAST(WAKE),
		.WAKE_SLOW(WAKE), .WCAL_FAST(WCAL), .WCAL_SLOW(WCAL), .RES_XTAL(XTAL)
	) u_adms_sequencer (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
		.stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat),
		.dat_o(dat_o), .ack_o(ack_o), .shift_clk_i(sclk),
		.power_down_n_i(pd_n), .ready_and_serial_out_o(sdo),
		.analog_power_o(apwr), .cal_signal_sel_o(csel));
	adms_host u_host (.clk_i(clk_i), .shift_clk_o(sclk),
		.power_down_n_o(pd_n));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [3:0] a,
		input logic [31:0] d, output logic [31:0] r);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= 4'hF;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		r = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask
	// Bounded so a dead line cannot stall the run
	task automatic wait_low(output int t);
		t = 0;
		while (sdo !== 1'b0 && t < 9000) begin
			@(posedge clk_i);
			t++;
		end
		// A line that never falls counts as a mismatch
		if (t >= 9000) errors++;
	endtask
	task automatic t_read_cal(input int cal);
		wait_low(n);
		for (int i = 23; i >= 0; i--) begin
			u_host.clocks(1);
			check(sdo, WORD[i]);
		end
		u_host.clocks(1);
		check(sdo, 1'b1);
		u_host.level(1'b1, 4);
		u_host.level(1'b0, 4);
		u_host.clocks(2);
		check({apwr, csel}, 2'b11);
		wait_low(n);
		check(n + 20 >= cal && n + 20 <= cal + 8, 1'b1);
		check(csel, 1'b0);
	endtask
	task automatic t_standby(input logic wcal, input int w);
		wait_low(n);
		// The held-high pulse is then the 25th rise
		if (wcal) u_host.clocks(24);
		u_host.level(1'b1, 12);
		check(apwr, 1'b1);
		u_host.level(1'b1, 28);
		check({apwr, sdo}, 2'b01);
		u_host.level(1'b0, 8);
		check({apwr, csel}, {1'b1, wcal});
		wait_low(n);
		check(n + 8 >= w && n + 8 <= w + 8, 1'b1);
	endtask
	task automatic t_short;
		wait_low(n);
		u_host.level(1'b1, 12);
		u_host.level(1'b0, 40);
		check({apwr, csel}, 2'b10);
	endtask
	task automatic t_pd(input logic [1:0] src, input int res);
		wb(1'b1, 4'h0, {29'h0000_0000, src, 1'b1}, q);
		wb(1'b0, 4'h0, 32'h0000_0000, q);
		check(q, {29'h0000_0000, src, 1'b1});
		wait_low(n);
		u_host.clocks(5);
		u_host.pd(1'b0, 260);
		check({apwr, sdo, csel}, 3'b010);
		// Status: power-down state, count cleared, line high
		wb(1'b0, 4'h8, 32'h0000_0000, q);
		check(q, 32'h0000_0800);
		u_host.pd(1'b1, 0);
		wait_low(n);
		check(n >= CONV + res && n <= CONV + res + 12, 1'b1);
	endtask
	task automatic complete_run;
		$display("Errors %0d, checks %0d", errors, check_count);
		if (errors == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// Whole run needs about 13000 cycles
	initial begin
		repeat (40000) @(posedge clk_i);
		errors++;
		complete_run();
	end
	initial begin
		clk_i = 1'b0;
		rst_i <= 1'b1;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		adr <= 4'h0;
		sel <= 4'h0;
		dat <= 32'h0000_0000;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		check({apwr, sdo, csel}, 3'b010);
		wb(1'b0, 4'h0, 32'h0000_0000, q);
		check(q, 32'h0000_0000);
		wb(1'b0, 4'h4, 32'h0000_0000, q);
		check(q, 32'h0000_0000);
		wb(1'b1, 4'hC, 32'hFFFF_FFFF, q);
		wb(1'b0, 4'hC, 32'h0000_0000, q);
		check(q, 32'h0000_0000);
		wb(1'b1, 4'h4, {8'h00, WORD}, q);
		wb(1'b0, 4'h4, 32'h0000_0000, q);
		check(q, {8'h00, WORD});
		wb(1'b1, 4'h0, 32'h0000_0001, q);
		u_host.power_up();
		t_read_cal(CAL_F);
		t_standby(1'b0, WAKE);
		t_standby(1'b1, WCAL);
		t_short();
		t_pd(adms_pkg::SRC_INTERNAL, adms_pkg::RES_INT_CYC);
		t_pd(adms_pkg::SRC_EXTERNAL, adms_pkg::RES_EXT_CYC);
		t_pd(adms_pkg::SRC_CRYSTAL, XTAL);
		wb(1'b1, 4'h0, 32'h0000_0000, q);
		t_read_cal(CAL_S);
		complete_run();
	end
endmodule
